// File: rtl/io_cell_bank.sv
// Purpose: Bank of pad logic cells with configuration sequencing and registers
// Assumes: 40 MHz clk; pad, power-on and loader signals are asynchronous
// Notes: Pads stay released only in the user state
//
// The placing of the registers and the strobed register port were chosen for this implementation.

`timescale 1ns/1ps

module io_cell_bank #(
   parameter int PIN_COUNT = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Configuration loader
   input wire logic por_b,
   input wire logic [1:0] boot_strap,
   input wire logic load_done,
   output logic load_start,
   output logic [1:0] load_source,
   // Bank freeze
   input wire logic bank_freeze,
   // Pads
   input wire logic [PIN_COUNT-1:0] pad_in,
   output logic [PIN_COUNT-1:0] pad_out,
   output logic [PIN_COUNT-1:0] pad_oe,
   output logic [PIN_COUNT-1:0] pad_pullup,
   // Core side
   input wire logic [PIN_COUNT-1:0] core_d_out0,
   input wire logic [PIN_COUNT-1:0] core_d_out1,
   input wire logic [PIN_COUNT-1:0] core_oe,
   output logic [PIN_COUNT-1:0] core_live,
   output logic core_in_valid,
   input wire logic core_in_ready,
   output logic [2*PIN_COUNT-1:0] core_in_data,
   // Clock synthesizer hold
   input wire logic synth_ref,
   output logic synth_out,
   output logic synth_low_power
);

   localparam int W = 2 * PIN_COUNT;

   function automatic logic hit(input logic [3:0] addr, input logic [3:0] offset);
      hit = addr == offset;
   endfunction

   // ----------------------------------------
   // Reset release and input synchronisers
   // ----------------------------------------
   logic rst_meta_reg, rst_n;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   logic [5:0] in_meta_reg, in_sync_reg;
   logic done_prev_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_meta_reg <= 6'h00;
         in_sync_reg <= 6'h00;
         done_prev_reg <= 1'b0;
      end else begin
         in_meta_reg <= {synth_ref, bank_freeze, boot_strap, load_done, por_b};
         in_sync_reg <= in_meta_reg;
         done_prev_reg <= in_sync_reg[1];
      end
   end

   wire logic por_up = in_sync_reg[0];
   wire logic done_sync = in_sync_reg[1];
   // Done may still stand from the last load; only a fresh rise ends a warm boot
   wire logic done_rise = done_sync & ~done_prev_reg;
   wire logic [1:0] strap_sync = in_sync_reg[3:2];
   wire logic freeze_sync = in_sync_reg[4];
   wire logic ref_sync = in_sync_reg[5];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] ctrl_reg, freeze_mask_reg, pullup_mask_reg, used_mask_reg, rdata_reg;
   io_cell_pkg::cfg_state_type cfg_state_reg, cfg_state_next;
   logic [1:0] load_source_reg, load_source_next;
   logic load_start_reg, load_start_next;
   logic [PIN_COUNT-1:0] pullup_out_reg, pad_oe_w, pad_out_w, d_in0_w, d_in1_w, live_w;
   logic synth_out_reg;

   wire logic wr_ctrl = reg_wr & hit(reg_addr, io_cell_pkg::CTRL_ADDR);
   wire logic wr_freeze = reg_wr & hit(reg_addr, io_cell_pkg::FREEZE_ADDR);
   wire logic wr_pullup = reg_wr & hit(reg_addr, io_cell_pkg::PULLUP_ADDR);
   wire logic wr_used = reg_wr & hit(reg_addr, io_cell_pkg::USED_ADDR);
   wire logic wr_boot = reg_wr & hit(reg_addr, io_cell_pkg::BOOT_ADDR);
   wire logic warm_req = wr_boot & reg_wdata[io_cell_pkg::BOOT_WARM];
   wire logic user_mode = cfg_state_reg == io_cell_pkg::CFG_USER;
   wire logic hold_en = ctrl_reg[io_cell_pkg::CTRL_HOLD];
   wire logic [PIN_COUNT-1:0] used_pins = used_mask_reg[PIN_COUNT-1:0];
   wire logic [PIN_COUNT-1:0] release_pins = {PIN_COUNT{user_mode}} & used_pins;
   wire logic buf_full;
   wire logic [7:0] status_w = {4'h0, buf_full, hold_en, 2'(cfg_state_reg)};
   wire logic [7:0] pad_level_w = 8'(live_w);
   wire logic [7:0] rd_mux =
      hit(reg_addr, io_cell_pkg::CTRL_ADDR) ? ctrl_reg :
      hit(reg_addr, io_cell_pkg::FREEZE_ADDR) ? freeze_mask_reg :
      hit(reg_addr, io_cell_pkg::PULLUP_ADDR) ? pullup_mask_reg :
      hit(reg_addr, io_cell_pkg::USED_ADDR) ? used_mask_reg :
      hit(reg_addr, io_cell_pkg::BOOT_ADDR) ? {6'h00, load_source_reg} :
      hit(reg_addr, io_cell_pkg::STATUS_ADDR) ? status_w :
      hit(reg_addr, io_cell_pkg::PAD_ADDR) ? pad_level_w : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= io_cell_pkg::CTRL_RESET;
         freeze_mask_reg <= io_cell_pkg::FREEZE_RESET;
         pullup_mask_reg <= io_cell_pkg::PULLUP_RESET;
         used_mask_reg <= io_cell_pkg::USED_RESET;
         rdata_reg <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= reg_wdata;
         end
         if (wr_freeze) begin
            freeze_mask_reg <= reg_wdata;
         end
         if (wr_pullup) begin
            pullup_mask_reg <= reg_wdata;
         end
         if (wr_used) begin
            used_mask_reg <= reg_wdata;
         end
         // Read data stands for one cycle only
         rdata_reg <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // ----------------------------------------
   // Configuration sequencing
   // ----------------------------------------
   always_comb begin
      cfg_state_next = cfg_state_reg;
      load_source_next = load_source_reg;
      load_start_next = 1'b0;
      case (cfg_state_reg)
         io_cell_pkg::CFG_POR: begin
            if (por_up) begin
               cfg_state_next = io_cell_pkg::CFG_LOAD;
               load_source_next = strap_sync;
               load_start_next = 1'b1;
            end
         end
         io_cell_pkg::CFG_LOAD: begin
            if (done_rise) begin
               cfg_state_next = io_cell_pkg::CFG_USER;
            end
         end
         io_cell_pkg::CFG_USER: begin
            if (warm_req) begin
               cfg_state_next = io_cell_pkg::CFG_LOAD;
               load_source_next = reg_wdata[io_cell_pkg::BOOT_SRC_LSB +: 2];
               load_start_next = 1'b1;
            end
         end
         default: begin
            cfg_state_next = io_cell_pkg::CFG_POR;
         end
      endcase
      // Power loss overrides the next state and load start and restarts from scratch
      if (!por_up) begin
         cfg_state_next = io_cell_pkg::CFG_POR;
         load_start_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_state_reg <= io_cell_pkg::CFG_POR;
         load_source_reg <= io_cell_pkg::SRC_RESET;
         load_start_reg <= 1'b0;
         pullup_out_reg <= '1;
         synth_out_reg <= 1'b0;
      end else begin
         cfg_state_reg <= cfg_state_next;
         load_source_reg <= load_source_next;
         load_start_reg <= load_start_next;
         pullup_out_reg <= user_mode ? (used_pins & pullup_mask_reg[PIN_COUNT-1:0]) : '1;
         synth_out_reg <= hold_en ? synth_out_reg : ref_sync;
      end
   end

   // ----------------------------------------
   // Cells and buffer
   // ----------------------------------------
   stream_if #(.WIDTH(W)) push_s ();
   stream_if #(.WIDTH(W)) pop_s ();

   wire logic in_ce = ctrl_reg[io_cell_pkg::CTRL_CLK_EN];
   // Stall holds the input registers so a refused pair is offered again
   wire logic in_en = in_ce & push_s.ready;

   assign buf_full = ~push_s.ready;
   assign push_s.valid = user_mode & in_ce;
   assign push_s.data = {d_in1_w, d_in0_w};
   assign pop_s.ready = core_in_ready;

   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++) begin : g_pin
         ddr_pad_cell u_cell (
            .clk(clk),
            .rst_n(rst_n),
            .pad_in(pad_in[g]),
            .pad_out(pad_out_w[g]),
            .pad_oe(pad_oe_w[g]),
            .ddr_in(ctrl_reg[io_cell_pkg::CTRL_DDR_IN]),
            .ddr_out(ctrl_reg[io_cell_pkg::CTRL_DDR_OUT]),
            .reg_out(ctrl_reg[io_cell_pkg::CTRL_REG_OUT]),
            .in_en(in_en),
            .out_en(in_ce),
            .freeze(freeze_sync),
            .freeze_en(freeze_mask_reg[g]),
            .release_pin(release_pins[g]),
            .d_out0(core_d_out0[g]),
            .d_out1(core_d_out1[g]),
            .oe(core_oe[g]),
            .d_in0(d_in0_w[g]),
            .d_in1(d_in1_w[g]),
            .live(live_w[g])
         );
      end
   endgenerate

   pair_buffer #(.WIDTH(W)) u_buffer (
      .clk(clk),
      .rst_n(rst_n),
      .in_s(push_s),
      .out_s(pop_s)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata = rdata_reg;
   assign load_start = load_start_reg;
   assign load_source = load_source_reg;
   assign pad_out = pad_out_w;
   assign pad_oe = pad_oe_w;
   assign pad_pullup = pullup_out_reg;
   assign core_live = live_w;
   assign core_in_valid = pop_s.valid;
   assign core_in_data = pop_s.data;
   assign synth_out = synth_out_reg;
   assign synth_low_power = hold_en;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_tristate_until_user;
      @(posedge clk) disable iff (!rst_n)
      !user_mode |=> pad_oe == '0 && pad_pullup == '1;
   endproperty
   a_tristate_until_user: assert property (p_tristate_until_user) else $error("Pin released early");

   property p_unused_blocked;
      @(posedge clk) disable iff (!rst_n)
      user_mode && !used_pins[0] |=> !pad_pullup[0] && !core_live[0] && !pad_oe[0];
   endproperty
   a_unused_blocked: assert property (p_unused_blocked) else $error("Unused pin not blocked");

   property p_load_on_por;
      @(posedge clk) disable iff (!rst_n)
      cfg_state_reg == io_cell_pkg::CFG_POR && por_up |=> cfg_state_reg == io_cell_pkg::CFG_LOAD && load_start
         ##1 !load_start;
   endproperty
   a_load_on_por: assert property (p_load_on_por) else $error("Download not started");

   property p_synth_hold;
      @(posedge clk) disable iff (!rst_n)
      hold_en && $past(hold_en) |-> $stable(synth_out_reg);
   endproperty
   a_synth_hold: assert property (p_synth_hold) else $error("Held clock output moved");

   property p_warm_boot;
      @(posedge clk) disable iff (!rst_n)
      user_mode && warm_req && por_up |=> cfg_state_reg == io_cell_pkg::CFG_LOAD
         && load_source == $past(reg_wdata[1:0]);
   endproperty
   a_warm_boot: assert property (p_warm_boot) else $error("Warm boot not taken");

   property p_pullup_option;
      @(posedge clk) disable iff (!rst_n)
      user_mode && used_pins[0] |=> pad_pullup[0] == $past(pullup_mask_reg[0]);
   endproperty
   a_pullup_option: assert property (p_pullup_option) else $error("Pull-up choice ignored");

   property p_load_waits_done;
      @(posedge clk) disable iff (!rst_n)
      cfg_state_reg == io_cell_pkg::CFG_LOAD && !done_rise |=> cfg_state_reg != io_cell_pkg::CFG_USER;
   endproperty
   a_load_waits_done: assert property (p_load_waits_done) else $error("Load ended early");

   property p_oe_follows_core;
      @(posedge clk) disable iff (!rst_n)
      user_mode && used_pins[0] |=> pad_oe[0] == $past(core_oe[0]);
   endproperty
   a_oe_follows_core: assert property (p_oe_follows_core) else $error("Output enable not followed");

   property p_power_loss;
      @(posedge clk) disable iff (!rst_n)
      !por_up |=> cfg_state_reg == io_cell_pkg::CFG_POR && !load_start;
   endproperty
   a_power_loss: assert property (p_power_loss) else $error("Power loss did not restart");

endmodule

// File: rtl/io_cell_pkg.sv
// Purpose: Shared constants and types for the pad logic cell bank
// Assumes: 8-bit register port, 4-bit register index
// Notes: Masks are 8 bits wide; a bank holds at most 8 pins

package io_cell_pkg;

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] FREEZE_ADDR = 4'h1;
   localparam logic [3:0] PULLUP_ADDR = 4'h2;
   localparam logic [3:0] USED_ADDR = 4'h3;
   localparam logic [3:0] BOOT_ADDR = 4'h4;
   localparam logic [3:0] STATUS_ADDR = 4'h5;
   localparam logic [3:0] PAD_ADDR = 4'h6;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_DDR_IN = 0;
   localparam int CTRL_DDR_OUT = 1;
   localparam int CTRL_REG_OUT = 2;
   localparam int CTRL_CLK_EN = 3;
   localparam int CTRL_HOLD = 4;
   localparam int BOOT_SRC_LSB = 0;
   localparam int BOOT_WARM = 2;
   localparam int STAT_HOLD = 2;
   localparam int STAT_BUF_FULL = 3;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [7:0] FREEZE_RESET = 8'h00;
   localparam logic [7:0] PULLUP_RESET = 8'hFF;
   localparam logic [7:0] USED_RESET = 8'hFF;
   localparam logic [1:0] SRC_RESET = 2'h0;

   // ----------------------------------------
   // Image sources and configuration states
   // ----------------------------------------
   localparam logic [1:0] SRC_STORE = 2'h0;
   localparam logic [1:0] SRC_FLASH = 2'h1;
   localparam logic [1:0] SRC_SLAVE = 2'h2;

   typedef enum logic [1:0] {CFG_POR, CFG_LOAD, CFG_USER} cfg_state_type;

endpackage

// File: rtl/stream_if.sv
// Purpose: Valid/ready word carrier between the cell bank and its buffer
// Assumes: Single clock domain
// Notes: Word moves when valid and ready are both high at a rising edge

`timescale 1ns/1ps

interface stream_if #(parameter int WIDTH = 8) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// File: rtl/pair_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Synchronised active-low reset
// Notes: Output side registered; ready upstream drops only when both entries hold

`timescale 1ns/1ps

module pair_buffer #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Streams
   stream_if.snk in_s,
   stream_if.src out_s
);

   logic out_valid_reg;
   logic skid_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic [WIDTH-1:0] skid_data_reg;

   wire logic drain = out_s.ready | ~out_valid_reg;
   wire logic take = in_s.valid & ~skid_valid_reg;

   assign in_s.ready = ~skid_valid_reg;
   assign out_s.valid = out_valid_reg;
   assign out_s.data = out_data_reg;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid_reg <= 1'b0;
         skid_valid_reg <= 1'b0;
         out_data_reg <= '0;
         skid_data_reg <= '0;
      end else if (drain) begin
         out_valid_reg <= skid_valid_reg | in_s.valid;
         out_data_reg <= skid_valid_reg ? skid_data_reg : in_s.data;
         skid_valid_reg <= 1'b0;
      end else if (take) begin
         // Second entry catches the word the receiver refused
         skid_valid_reg <= 1'b1;
         skid_data_reg <= in_s.data;
      end
   end

   property p_stall_hold;
      @(posedge clk) disable iff (!rst_n)
      out_valid_reg && !out_s.ready |=> out_valid_reg && $stable(out_data_reg);
   endproperty
   a_stall_hold: assert property (p_stall_hold) else $error("Stalled word changed");

   property p_no_loss;
      @(posedge clk) disable iff (!rst_n)
      in_s.valid && in_s.ready && out_valid_reg && !out_s.ready |=> skid_valid_reg && !in_s.ready;
   endproperty
   a_no_loss: assert property (p_no_loss) else $error("Refused word not kept");

endmodule

// File: rtl/ddr_pad_cell.sv
// Purpose: One pad's input, output and tri-state register blocks
// Assumes: Pad input is asynchronous; core signals are on clk
// Notes: Falling-edge registers capture the second bit of each pair

`timescale 1ns/1ps

module ddr_pad_cell (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pad side
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   // Mode
   input wire logic ddr_in,
   input wire logic ddr_out,
   input wire logic reg_out,
   input wire logic in_en,
   input wire logic out_en,
   input wire logic freeze,
   input wire logic freeze_en,
   input wire logic release_pin,
   // Core side
   input wire logic d_out0,
   input wire logic d_out1,
   input wire logic oe,
   output logic d_in0,
   output logic d_in1,
   output logic live
);

   logic rise_meta_reg, rise_sync_reg, fall_meta_reg, fall_sync_reg;
   logic in0_reg, in1_reg, out0_reg, out1_reg, oe_reg, live_reg;

   wire logic hold_live = freeze & freeze_en;
   wire logic second_bit = ddr_in ? fall_sync_reg : rise_sync_reg;
   // Mux on clk level: low half of the period shows the falling-edge bit
   wire logic reg_data = (ddr_out & ~clk) ? out1_reg : out0_reg;

   assign pad_out = reg_out ? reg_data : d_out0;
   assign pad_oe = oe_reg;
   assign d_in0 = in0_reg;
   assign d_in1 = in1_reg;
   assign live = live_reg;

   // ----------------------------------------
   // Rising-edge registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rise_meta_reg <= 1'b0;
         rise_sync_reg <= 1'b0;
         in0_reg <= 1'b0;
         in1_reg <= 1'b0;
         out0_reg <= 1'b0;
         oe_reg <= 1'b0;
         live_reg <= 1'b0;
      end else begin
         rise_meta_reg <= pad_in;
         rise_sync_reg <= rise_meta_reg;
         if (in_en) begin
            in0_reg <= release_pin & rise_sync_reg;
            in1_reg <= release_pin & second_bit;
         end
         if (out_en) begin
            out0_reg <= d_out0;
         end
         oe_reg <= release_pin & oe;
         live_reg <= !release_pin ? 1'b0 : (hold_live ? live_reg : rise_sync_reg);
      end
   end

   // ----------------------------------------
   // Falling-edge registers
   // ----------------------------------------
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fall_meta_reg <= 1'b0;
         fall_sync_reg <= 1'b0;
         out1_reg <= 1'b0;
      end else begin
         fall_meta_reg <= pad_in;
         fall_sync_reg <= fall_meta_reg;
         if (out_en) begin
            out1_reg <= d_out1;
         end
      end
   end

   property p_freeze_hold;
      @(posedge clk) disable iff (!rst_n)
      release_pin && hold_live && $past(release_pin) && $past(hold_live) |-> $stable(live_reg);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("Frozen input moved");

   property p_ce_hold;
      @(posedge clk) disable iff (!rst_n)
      !in_en |=> $stable(in0_reg) && $stable(in1_reg);
   endproperty
   a_ce_hold: assert property (p_ce_hold) else $error("Input register moved while disabled");

   property p_rise_first;
      @(posedge clk) disable iff (!rst_n)
      in_en && release_pin |=> in0_reg == $past(rise_sync_reg);
   endproperty
   a_rise_first: assert property (p_rise_first) else $error("First bit not rising sample");

endmodule

// File: testbench/loader_model.sv
// Purpose: Configuration loader at the bank's far side
// Assumes: One clock, level done flag
// Notes: Answers each start after LAT cycles
`timescale 1ns/1ps
module loader_model #(
   parameter int LAT = 4
) (
   // Clock
   input wire logic clk,
   // Loader link
   input wire logic load_start,
   output logic load_done
);
   int cnt = 0;
   initial load_done = 1'b0;
   // New image restarts the load, so done drops first
   always @(posedge clk) begin
      if (load_start) begin
         load_done <= 1'b0;
         cnt <= LAT;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         load_done <= 1'b1;
         cnt <= 0;
      end
   end
endmodule

// File: testbench/io_cell_bank_tb.sv
// Purpose: Self-checking bench for the pad logic cell bank
// Assumes: 40 MHz clock, four pins
// Notes: Pads and core side driven by the bench
`timescale 1ns/1ps
module io_cell_bank_tb;
   // ----------------------------
   // Signals
   // ----------------------------
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic por_b = 1'b0;
   logic [1:0] boot_strap = 2'h1;
   logic bank_freeze = 1'b0;
   logic [3:0] pad_in = 4'h0;
   logic [3:0] d0 = 4'h0;
   logic [3:0] d1 = 4'h0;
   logic [3:0] coe = 4'hF;
   logic core_in_ready = 1'b1;
   logic synth_ref = 1'b0;
   logic [7:0] reg_rdata, core_in_data;
   logic load_done, load_start, core_in_valid, synth_out, synth_low_power;
   logic [1:0] load_source;
   logic [3:0] pad_out, pad_oe, pad_pullup, core_live;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;

   io_cell_bank #(.PIN_COUNT(4)) i_io_cell_bank (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_b(por_b),
      .boot_strap(boot_strap), .load_done(load_done), .load_start(load_start), .load_source(load_source),
      .bank_freeze(bank_freeze), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
      .core_d_out0(d0), .core_d_out1(d1), .core_oe(coe), .core_live(core_live), .core_in_valid(core_in_valid),
      .core_in_ready(core_in_ready), .core_in_data(core_in_data), .synth_ref(synth_ref), .synth_out(synth_out),
      .synth_low_power(synth_low_power));
   loader_model #(.LAT(4)) i_loader_model (.clk(clk), .load_start(load_start), .load_done(load_done));

   initial forever #12.5 clk = ~clk;
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         finish_test();
      end
   end

   // ----------------------------
   // Tasks
   // ----------------------------
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, e, reg_rdata);
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_start(input logic [1:0] s);
      int k;
      k = 0;
      #1;
      while (load_start !== 1'b1 && k < 8) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk("load_start", 8'h01, {7'h0, load_start});
      chk("load_source", {6'h0, s}, {6'h0, load_source});
      // Pads let go one edge after the state leaves user
      @(posedge clk);
      #1;
      chk("pad_oe_load", 8'h00, {4'h0, pad_oe});
   endtask

   // ----------------------------
   // Sequence
   // ----------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      waitc(4);
      chk("pad_oe_por", 8'h00, {4'h0, pad_oe});
      chk("pullup_por", 8'h0F, {4'h0, pad_pullup});
      rchk("ctrl", 4'h0, io_cell_pkg::CTRL_RESET);
      rchk("freeze", 4'h1, io_cell_pkg::FREEZE_RESET);
      rchk("pullup", 4'h2, io_cell_pkg::PULLUP_RESET);
      rchk("used", 4'h3, io_cell_pkg::USED_RESET);
      rchk("unmapped", 4'hF, 8'h00);
      rchk("status_por", 4'h5, 8'h00);
      por_b <= 1'b1;
      wait_start(2'h1);
      waitc(15);
      rchk("status_user", 4'h5, 8'h02);
      d0 <= 4'hA;
      coe <= 4'h5;
      waitc(3);
      chk("pad_out_direct", 8'h0A, {4'h0, pad_out});
      chk("pad_oe", 8'h05, {4'h0, pad_oe});
      d0 <= 4'h3;
      d1 <= 4'hC;
      wr(4'h0, 8'h0E);
      waitc(3);
      chk("ddr_out_rise", 8'h03, {4'h0, pad_out});
      @(negedge clk);
      #1;
      chk("ddr_out_fall", 8'h0C, {4'h0, pad_out});
      pad_in <= 4'h9;
      wr(4'h0, 8'h09);
      waitc(8);
      chk("ddr_in_data", 8'h99, core_in_data);
      rchk("pad_level", 4'h6, 8'h09);
      wr(4'h1, 8'h01);
      bank_freeze <= 1'b1;
      waitc(4);
      pad_in <= 4'h6;
      waitc(6);
      chk("live_frozen", 8'h07, {4'h0, core_live});
      bank_freeze <= 1'b0;
      waitc(5);
      chk("live_thaw", 8'h06, {4'h0, core_live});
      core_in_ready <= 1'b0;
      waitc(6);
      rchk("status_full", 4'h5, 8'h0A);
      pad_in <= 4'hF;
      waitc(6);
      chk("stall_data", 8'h66, core_in_data);
      core_in_ready <= 1'b1;
      waitc(8);
      chk("drain_data", 8'hFF, core_in_data);
      // Reference must pass its synchroniser before the hold lands
      synth_ref <= 1'b1;
      wr(4'h0, 8'h00);
      waitc(6);
      chk("clk_en_off", 8'h00, {7'h0, core_in_valid});
      wr(4'h0, 8'h18);
      waitc(4);
      chk("low_power", 8'h01, {7'h0, synth_low_power});
      synth_ref <= 1'b0;
      waitc(5);
      chk("synth_held", 8'h01, {7'h0, synth_out});
      wr(4'h0, 8'h08);
      waitc(5);
      chk("synth_run", 8'h00, {7'h0, synth_out});
      wr(4'h2, 8'h05);
      wr(4'h3, 8'h0E);
      waitc(3);
      chk("pullup_used", 8'h04, {4'h0, pad_pullup});
      chk("live_unused", 8'h0E, {4'h0, core_live});
      chk("oe_unused", 8'h04, {4'h0, pad_oe});
      foreach (boot_strap[i]) begin
         wr(4'h4, {5'h0, 1'b1, ~i[0], 1'b0});
         wait_start({1'b0, ~i[0]} << 1);
         rchk("status_load", 4'h5, 8'h01);
         waitc(15);
         rchk("boot_src", 4'h4, {6'h0, 1'b0, ~i[0]} << 1);
         rchk("status_warm", 4'h5, 8'h02);
      end
      finish_test();
   end
endmodule
